// file: src/fdg_fs_gen.sv
`timescale 1ns/1ps
module fdg_fs_gen (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire fdg_pkg::fdg_div_s div_i,
    input wire logic fast_bclk_i,
    output logic fs_tick_o,
    output logic bclk_tick_o
);
    import fdg_pkg::*;

    logic [17:0] fs_cnt_reg;
    logic [17:0] fs_limit;
    logic [3:0] bclk_cnt_reg;

    // Frame period is the master clock times 16*M*N*P.
    assign fs_limit = 18'(FS_BASE_DIV * div_i.m * div_i.n * div_i.p - 1); // [RULE_03]

    // Frame counter emits one tick per frame-sync period.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || fs_cnt_reg >= fs_limit) begin
            fs_cnt_reg <= '0;
        end else begin
            fs_cnt_reg <= fs_cnt_reg + 18'h0001;
        end
    end
    assign fs_tick_o = (fs_cnt_reg >= fs_limit) && !reset_i;

    // Fast bit clock ticks once every P master clocks.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !fast_bclk_i || {1'b0, bclk_cnt_reg} >= 5'(div_i.p - 4'h1)) begin
            bclk_cnt_reg <= '0;
        end else begin
            bclk_cnt_reg <= bclk_cnt_reg + 4'h1;
        end
    end
    assign bclk_tick_o = fast_bclk_i && !reset_i && ({1'b0, bclk_cnt_reg} >= 5'(div_i.p - 4'h1)); // [RULE_15]
endmodule

// file: src/fdg_gain_decode.sv
`timescale 1ns/1ps
module fdg_gain_decode (
    input wire logic [5:0] code_i,
    output logic mute_o,
    output logic signed [6:0] gain_db_o
);
    import fdg_pkg::*;

    // All ones mutes; otherwise each step below the top code drops 1 dB.
    assign mute_o = (code_i == GAIN_MUTE); // [RULE_13]
    assign gain_db_o = 7'(signed'({1'b0, code_i}) - GAIN_TOP_CODE + GAIN_TOP_DB); // [RULE_13]
endmodule

// file: src/fdg_pkg.sv
package fdg_pkg;

    // ------------------------------------------------------------
    // Register access and field layout
    // ------------------------------------------------------------
    localparam logic [0:0] ADDR_FRAME_DIV = 1'h0;
    localparam logic [0:0] ADDR_GAIN = 1'h1;
    localparam int SEL_BIT = 7;
    localparam int SUB_HI = 7;
    localparam int SUB_LO = 6;
    localparam logic [1:0] SUB_ADC = 2'h0;
    localparam logic [1:0] SUB_DAC = 2'h1;
    localparam logic [1:0] SUB_SIDE = 2'h2;
    localparam logic [1:0] SUB_FOURTH = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] M_RESET = 7'h10;
    localparam logic [3:0] N_RESET = 4'h6;
    localparam logic [2:0] P_RESET = 3'h0;
    localparam logic [5:0] GAIN_RESET = 6'h2a;
    localparam logic [7:0] SIDE_RESET = 8'h38;
    localparam logic [7:0] FOURTH_RESET = 8'h00;

    // ------------------------------------------------------------
    // Divider and gain constants
    // ------------------------------------------------------------
    localparam int FS_BASE_DIV = 16;
    localparam int SAMPLE_SETTLE = 2;
    localparam logic [5:0] GAIN_MUTE = 6'h3f;
    localparam int GAIN_TOP_DB = 20;
    localparam int GAIN_TOP_CODE = 62;

    // Effective divider values.
    typedef struct packed {
        logic [7:0] m;
        logic [4:0] n;
        logic [3:0] p;
    } fdg_div_s;

    // Host register access.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [0:0] addr;
        logic [7:0] wdata;
    } fdg_req_s;

endpackage

// file: src/fdg_regs.sv
`timescale 1ns/1ps
// Operation
// [RULE_01] Select 0 write loads N and P.
// [RULE_02] Select 1 write loads M.
// [RULE_03] Frame rate is clock over 16*M*N*P.
// [RULE_04] M field zero means 128.
// [RULE_05] N field zero means 16.
// [RULE_06] P field zero means 8.
// [RULE_07] New dividers apply after two frames.
// [RULE_08] Divider reads alternate N/P then M.
// [RULE_09] Reset dividers M 16, N 6, P 8.
// [RULE_10] P of 8 selects coarse sampling.
// [RULE_11] Gain sub-address 00 writes ADC gain.
// [RULE_12] ADC and DAC gain reset to 0 dB.
// [RULE_13] Gain code decodes mute, +20 to -42 dB.
// [RULE_14] Gain reads cycle ADC, DAC, sidetone, fourth.
// [RULE_15] Fast bit clock is clock over P.
// [RULE_16] Each divider write keeps the other fields.
module fdg_regs (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire fdg_pkg::fdg_req_s req_i,
    input wire logic fast_bclk_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [7:0] eff_m_o,
    output logic [4:0] eff_n_o,
    output logic [3:0] eff_p_o,
    output logic coarse_mode_o,
    output logic [5:0] adc_gain_code_o,
    output logic [5:0] dac_gain_code_o,
    output logic adc_mute_o,
    output logic signed [6:0] adc_gain_db_o,
    output logic fs_tick_o,
    output logic bclk_tick_o
);
    import fdg_pkg::*;

    // ------------------------------------------------------------
    // Field decoding
    // ------------------------------------------------------------

    // A zero field stands for the top of its range.
    function automatic logic [7:0] field_value(input logic [6:0] f, input logic [7:0] full);
        field_value = (f == 7'h00) ? full : {1'b0, f};
    endfunction

    logic [6:0] m_reg;
    logic [3:0] n_reg;
    logic [2:0] p_reg;
    logic read_m_reg;
    logic [1:0] gain_rd_reg;
    logic [5:0] adc_gain_reg;
    logic [5:0] dac_gain_reg;
    logic [7:0] side_reg;
    logic [7:0] fourth_reg;
    logic [1:0] settle_reg;
    logic pending_reg;
    fdg_div_s active_reg;
    fdg_div_s staged;
    logic wr_div;
    logic wr_gain;
    logic rd_div;
    logic rd_gain;
    logic [1:0] sub;
    logic fs_tick;
    logic bclk_tick;
    logic mute;
    logic signed [6:0] gain_db;
    logic [7:0] rdata_next;

    assign wr_div = req_i.wr && (req_i.addr == ADDR_FRAME_DIV);
    assign wr_gain = req_i.wr && (req_i.addr == ADDR_GAIN);
    assign rd_div = req_i.rd && (req_i.addr == ADDR_FRAME_DIV);
    assign rd_gain = req_i.rd && (req_i.addr == ADDR_GAIN);
    assign sub = req_i.wdata[SUB_HI:SUB_LO];

    // Programmed fields mapped to their effective divider values.
    assign staged.m = field_value(m_reg, 8'h80); // [RULE_04]
    assign staged.n = 5'(field_value({3'h0, n_reg}, 8'h10)); // [RULE_05]
    assign staged.p = 4'(field_value({4'h0, p_reg}, 8'h08)); // [RULE_06]

    // ------------------------------------------------------------
    // Divider register
    // ------------------------------------------------------------

    // Select bit steers the write; unselected fields hold.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            m_reg <= M_RESET; // [RULE_09]
            n_reg <= N_RESET; // [RULE_09]
            p_reg <= P_RESET; // [RULE_09]
        end else if (wr_div && req_i.wdata[SEL_BIT]) begin
            m_reg <= req_i.wdata[6:0]; // [RULE_02] [RULE_16]
        end else if (wr_div) begin
            n_reg <= req_i.wdata[6:3]; // [RULE_01] [RULE_16]
            p_reg <= req_i.wdata[2:0]; // [RULE_01]
        end
    end

    // New values wait two frame periods before they drive the frame rate.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            active_reg <= '{m: 8'h10, n: 5'h06, p: 4'h8};
            pending_reg <= 1'b0;
            settle_reg <= '0;
        end else if (wr_div) begin
            pending_reg <= 1'b1;
            settle_reg <= '0;
        end else if (pending_reg && fs_tick) begin
            if (settle_reg == 2'(SAMPLE_SETTLE - 1)) begin
                active_reg <= staged; // [RULE_07]
                pending_reg <= 1'b0;
            end
            settle_reg <= settle_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Gain registers
    // ------------------------------------------------------------

    // Sub-address in the top bits selects which gain register is written.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            adc_gain_reg <= GAIN_RESET; // [RULE_12]
            dac_gain_reg <= GAIN_RESET; // [RULE_12]
            side_reg <= SIDE_RESET;
            fourth_reg <= FOURTH_RESET;
        end else if (wr_gain) begin
            unique case (sub)
                SUB_ADC: adc_gain_reg <= req_i.wdata[5:0]; // [RULE_11]
                SUB_DAC: dac_gain_reg <= req_i.wdata[5:0];
                SUB_SIDE: side_reg <= req_i.wdata;
                SUB_FOURTH: fourth_reg <= req_i.wdata;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read sequencing
    // ------------------------------------------------------------

    // Read data per address, advancing through sub-registers.
    always_comb begin
        rdata_next = 8'h00;
        if (rd_div) begin
            rdata_next = read_m_reg ? {1'b1, m_reg} : {1'b0, n_reg, p_reg}; // [RULE_08]
        end else if (rd_gain) begin
            unique case (gain_rd_reg)
                SUB_ADC: rdata_next = {SUB_ADC, adc_gain_reg}; // [RULE_14]
                SUB_DAC: rdata_next = {SUB_DAC, dac_gain_reg};
                SUB_SIDE: rdata_next = side_reg;
                SUB_FOURTH: rdata_next = fourth_reg;
            endcase
        end
    end

    // Read pointers step on each read; any write restarts them.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || req_i.wr) begin
            read_m_reg <= 1'b0;
            gain_rd_reg <= SUB_ADC;
        end else begin
            if (rd_div) begin
                read_m_reg <= !read_m_reg; // [RULE_08]
            end
            if (rd_gain) begin
                gain_rd_reg <= gain_rd_reg + 2'h1; // [RULE_14]
            end
        end
    end

    // ------------------------------------------------------------
    // Timing generation and decode
    // ------------------------------------------------------------

    fdg_fs_gen u_fs_gen (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .div_i(active_reg),
        .fast_bclk_i(fast_bclk_i),
        .fs_tick_o(fs_tick),
        .bclk_tick_o(bclk_tick)
    );

    fdg_gain_decode u_gain_decode (
        .code_i(adc_gain_reg),
        .mute_o(mute),
        .gain_db_o(gain_db)
    );

    // All outputs are registered.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            eff_m_o <= 8'h10;
            eff_n_o <= 5'h06;
            eff_p_o <= 4'h8;
            coarse_mode_o <= 1'b1;
            adc_gain_code_o <= GAIN_RESET;
            dac_gain_code_o <= GAIN_RESET;
            adc_mute_o <= 1'b0;
            adc_gain_db_o <= 7'sh00;
            fs_tick_o <= 1'b0;
            bclk_tick_o <= 1'b0;
        end else begin
            rdata_o <= rdata_next;
            rvalid_o <= req_i.rd;
            eff_m_o <= active_reg.m;
            eff_n_o <= active_reg.n;
            eff_p_o <= active_reg.p;
            coarse_mode_o <= (active_reg.p == 4'h8); // [RULE_10]
            adc_gain_code_o <= adc_gain_reg;
            dac_gain_code_o <= dac_gain_reg;
            adc_mute_o <= mute; // [RULE_13]
            adc_gain_db_o <= gain_db;
            fs_tick_o <= fs_tick; // [RULE_03]
            bclk_tick_o <= bclk_tick; // [RULE_15]
        end
    end
endmodule

// file: test/fdg_host_model.sv
`timescale 1ns/1ps
module fdg_host_model (
    input wire logic ref_clk_i,
    output fdg_pkg::fdg_req_s req_o
);
    import fdg_pkg::*;
    // The host idles from time zero so no strobe reaches the block early.
    initial req_o = '0;
    // One strobe cycle; between accesses address and data show the inverse of the last value.
    task automatic access(input logic wr, input logic [0:0] addr, input logic [7:0] data);
        @(negedge ref_clk_i);
        req_o = '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask
endmodule

// file: test/fdg_props.sv
`timescale 1ns/1ps
module fdg_props (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire fdg_pkg::fdg_req_s req_i,
    input wire logic fast_bclk_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [7:0] eff_m_o,
    input wire logic [4:0] eff_n_o,
    input wire logic [3:0] eff_p_o,
    input wire logic coarse_mode_o,
    input wire logic [5:0] adc_gain_code_o,
    input wire logic [5:0] dac_gain_code_o,
    input wire logic adc_mute_o,
    input wire logic signed [6:0] adc_gain_db_o,
    input wire logic fs_tick_o,
    input wire logic bclk_tick_o
);
    import fdg_pkg::*;
    int fs_cnt;
    int bk_cnt;
    logic fs_ok;
    logic bk_ok;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ------------------------------------------------------------
    // Tick spacing
    // ------------------------------------------------------------
    // Counters restart on each tick; a period is judged only if the dividers held still.
    always_ff @(posedge ref_clk_i) begin
        fs_cnt <= (reset_i || fs_tick_o) ? 1 : fs_cnt + 1;
        bk_cnt <= (reset_i || bclk_tick_o) ? 1 : bk_cnt + 1;
        fs_ok <= !reset_i && (fs_tick_o || (fs_ok && $stable({eff_m_o, eff_n_o, eff_p_o})));
        bk_ok <= !reset_i && fast_bclk_i && (bclk_tick_o || (bk_ok && $stable(eff_p_o)));
    end
    chk_rd_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    chk_rvalid_cause: assert property (rvalid_o |-> $past(req_i.rd))
        else $error("answer without read");
    chk_coarse_mode: assert property (coarse_mode_o == (eff_p_o == 4'h8))
        else $error("coarse mode wrong");
    chk_eff_range: assert property (eff_m_o inside {[1:128]} && eff_n_o inside {[1:16]} && eff_p_o inside {[1:8]})
        else $error("divider out of range");
    chk_gain_mute: assert property ($stable(adc_gain_code_o) |-> adc_mute_o == (adc_gain_code_o == GAIN_MUTE))
        else $error("mute decode wrong");
    chk_eff_after_tick: assert property ($changed({eff_m_o, eff_n_o, eff_p_o}) |-> $past(fs_tick_o))
        else $error("divider changed off frame");
    chk_fs_period: assert property (fs_tick_o && fs_ok |-> fs_cnt == FS_BASE_DIV * eff_m_o * eff_n_o * eff_p_o)
        else $error("frame period wrong");
    // A tick in the cycle where the visible P changes belongs to the old spacing, so it is not judged.
    chk_bclk_period: assert property (bclk_tick_o && bk_ok && fast_bclk_i && $stable(eff_p_o) |-> bk_cnt == eff_p_o)
        else $error("bit clock period wrong");
    chk_reset_values: assert property ($fell(reset_i) |-> eff_m_o == 8'h10 && eff_n_o == 5'h06 && eff_p_o == 4'h8 && adc_gain_code_o == 6'h2a && dac_gain_code_o == 6'h2a)
        else $error("reset values wrong");
    cover property (fs_tick_o && fs_ok);
    cover property (bclk_tick_o && bk_ok);
    cover property (adc_mute_o);
endmodule
bind fdg_regs fdg_props u_fdg_props (.*);

// file: test/fdg_regs_test.sv
`timescale 1ns/1ps
module fdg_regs_test;
    import fdg_pkg::*;
    logic ref_clk_i;
    logic reset_i;
    logic fast_bclk_i;
    fdg_req_s req;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] eff_m;
    logic [4:0] eff_n;
    logic [3:0] eff_p;
    logic coarse;
    logic [5:0] adc_code;
    logic [5:0] dac_code;
    logic mute;
    logic signed [6:0] db;
    logic fs_tick;
    logic bclk_tick;
    logic [7:0] exp_q[$];
    logic [5:0] gain_edge[3] = '{6'h3e, 6'h00, 6'h3f};
    logic [5:0] code;
    int err_total = 0;
    int n_checks = 0;
    fdg_regs u_fdg_regs (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req), .fast_bclk_i(fast_bclk_i),
        .rdata_o(rdata), .rvalid_o(rvalid), .eff_m_o(eff_m), .eff_n_o(eff_n), .eff_p_o(eff_p),
        .coarse_mode_o(coarse), .adc_gain_code_o(adc_code), .dac_gain_code_o(dac_code),
        .adc_mute_o(mute), .adc_gain_db_o(db), .fs_tick_o(fs_tick), .bclk_tick_o(bclk_tick));
    fdg_host_model u_fdg_host_model (.ref_clk_i(ref_clk_i), .req_o(req));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [0:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        u_fdg_host_model.access(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [0:0] a, input logic [7:0] d);
        u_fdg_host_model.access(1'b1, a, d);
    endtask
    // Waits a bounded time for the active dividers to reach a set, then compares them.
    task automatic wait_eff(input logic [7:0] m, input logic [4:0] n, input logic [3:0] p);
        int k;
        k = 0;
        while (k < 30000 && !(eff_m === m && eff_n === n && eff_p === p)) begin
            @(negedge ref_clk_i);
            k++;
        end
        check8("eff_m", m, eff_m);
        check8("eff_n", {3'h0, n}, {3'h0, eff_n});
        check8("eff_p", {4'h0, p}, {4'h0, eff_p});
        check8("coarse", {7'h0, p == 4'h8}, {7'h0, coarse});
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Free-running clock at 40 MHz.
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // The slowest settling takes about 25000 cycles, so 100000 cycles means a hang.
    initial begin
        #(25 * 100000);
        err_total++;
        final_report();
    end
    // Each read answer is matched against the oldest pending expectation.
    always @(posedge ref_clk_i) begin
        #1;
        if (rvalid === 1'b1) begin
            check8("rdata", (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata, rdata);
        end
    end
    // Main sequence: defaults, divider loads, zero fields, gain codes, reset in mid-run.
    initial begin
        reset_i = 1'b1;
        fast_bclk_i = 1'b1;
        void'($urandom(32'h9a24));
        repeat (20) @(negedge ref_clk_i);
        reset_i = 1'b0;
        rd(ADDR_FRAME_DIV, 8'h30);
        rd(ADDR_FRAME_DIV, 8'h90);
        rd(ADDR_GAIN, 8'h2a);
        rd(ADDR_GAIN, 8'h6a);
        rd(ADDR_GAIN, SIDE_RESET);
        rd(ADDR_GAIN, FOURTH_RESET);
        check8("dac_code", {2'h0, GAIN_RESET}, {2'h0, dac_code});
        check8("adc_code", {2'h0, GAIN_RESET}, {2'h0, adc_code});
        wr(ADDR_FRAME_DIV, 8'h81);
        wr(ADDR_FRAME_DIV, 8'h09);
        check8("eff_m", 8'h10, eff_m);
        rd(ADDR_FRAME_DIV, 8'h09);
        rd(ADDR_FRAME_DIV, 8'h81);
        wait_eff(8'd1, 5'd1, 4'd1);
        wr(ADDR_FRAME_DIV, 8'h80);
        wait_eff(8'd128, 5'd1, 4'd1);
        wr(ADDR_FRAME_DIV, 8'h81);
        wr(ADDR_FRAME_DIV, 8'h00);
        wait_eff(8'd1, 5'd16, 4'd8);
        for (int i = 0; i < 8; i++) begin
            code = (i < 3) ? gain_edge[i] : 6'($urandom_range(0, 63));
            wr(ADDR_GAIN, {SUB_ADC, code});
            @(negedge ref_clk_i);
            check8("adc_code", {2'h0, code}, {2'h0, adc_code});
            check8("mute", {7'h0, code == 6'h3f}, {7'h0, mute});
            if (code != 6'h3f) check8("db", 8'(int'(code) - 42), 8'(db));
            rd(ADDR_GAIN, {2'h0, code});
        end
        repeat (2) @(negedge ref_clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        reset_i = 1'b0;
        rd(ADDR_FRAME_DIV, 8'h30);
        rd(ADDR_GAIN, 8'h2a);
        fast_bclk_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        final_report();
    end
endmodule
